// ---- hdl/rtcaw_map.svh ----
// Purpose: register offsets, field positions and timing constants of the alarm/watchdog block
// Assumes: 50 MHz sys_clk, 0.01 s time base derived internally
// Notes: included by the top module only
// Summary of operation
// - day alarm bits 3..6 read zero
// - masks clear: match minutes, hours and day
// - day mask only: daily on hour/minute match
// - day and hour masked: hourly on minute match
// - alarm registers keep time register format
// - alarm register access clears alarm flag
// - two BCD watchdog bytes, 00.01 to 99.99
// - watchdog access reloads count, clears flag
// - count down, alarm at zero, repeat
// - watchdog reads return loaded period
// - zero period disables the watchdog
// - transfer enable freezes visible clock copies
// - route bit swaps the two interrupt pins
// - polarity bit sets second pin active level
// - pulse bit: pulses of at least 3 ms
// - watchdog mask bit gates watchdog interrupt
// - alarm mask bit gates alarm interrupt
// - read-only watchdog flag, pulse-qualified
// - read-only alarm flag, pulse-qualified
// - compare while hundredths hold final value
// - addresses 0x00..0x3F select on-chip registers
`ifndef RTCAW_MAP_SVH
`define RTCAW_MAP_SVH
`define RTCAW_OFF_MIN_ALARM 6'h03
`define RTCAW_OFF_HOUR_ALARM 6'h05
`define RTCAW_OFF_DAY_ALARM 6'h07
`define RTCAW_OFF_COMMAND 6'h0b
`define RTCAW_OFF_WDOG_LOW 6'h0c
`define RTCAW_OFF_WDOG_HIGH 6'h0d
`define RTCAW_REG_SPACE_TOP 17'h0_003f
`define RTCAW_DAY_ALARM_KEEP 8'h87
`define RTCAW_MASK_BIT 7
`define RTCAW_CMD_XFER_EN 7
`define RTCAW_CMD_SWAP 6
`define RTCAW_CMD_POL 5
`define RTCAW_CMD_PULSE 4
`define RTCAW_CMD_WDOG_MASK 3
`define RTCAW_CMD_ALARM_MASK 2
`define RTCAW_CMD_WDOG_FLAG 1
`define RTCAW_CMD_ALARM_FLAG 0
`define RTCAW_CMD_RW_MASK 8'hfc
`define RTCAW_RESET_BYTE 8'h00
`define RTCAW_CMD_RESET 8'h80
`define RTCAW_SYNC_IDLE 28'h00e_0000
`define RTCAW_CLK_HZ 50000000
`define RTCAW_TICK_HZ 100
`define RTCAW_PULSE_MS 3
`define RTCAW_HUND_LAST 8'h99
`define RTCAW_SEC_LAST 8'h59
`endif

// ---- hdl/rtcaw_pkg.sv ----
// Purpose: types shared by the alarm/watchdog block
// Assumes: nothing beyond the map header
// Notes: carriers of the time inputs and the command bits
package rtcaw_pkg;
    typedef struct packed {
        logic [7:0] hund;
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] day;
    } rtcaw_time_t;
    typedef struct packed {
        logic transfer_enable;
        logic irq_route_swap;
        logic second_irq_drive_polarity;
        logic irq_pulse_select;
        logic watchdog_irq_mask;
        logic alarm_irq_mask;
    } rtcaw_cmd_t;
endpackage

// ---- hdl/rtcaw_top.sv ----
// Purpose: alarm compare, watchdog countdown and interrupt routing of a bytewide clock controller
// Assumes: host bus pins are asynchronous and pass two flops; time counters come from same-clock logic
// Notes: access is taken on the rising edge of the combined select; a watchdog write reloads again at the end of the strobe
`timescale 1ns/1ns
`default_nettype none
`include "rtcaw_map.svh"
module rtcaw_top #(
    parameter int CLK_HZ = `RTCAW_CLK_HZ,
    parameter int TICK_DIV = CLK_HZ / `RTCAW_TICK_HZ,
    parameter int PULSE_CYC = (CLK_HZ / 1000) * `RTCAW_PULSE_MS
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [16:0] addr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    input wire logic chip_enable_n,
    input wire logic output_enable_n,
    input wire logic write_enable_n,
    input wire rtcaw_pkg::rtcaw_time_t time_now,
    output logic tick,
    output logic transfer_enable,
    output logic irq_pin_first_out,
    output logic irq_pin_first_oe,
    output logic irq_pin_second_out,
    output logic irq_pin_second_oe
);
    // ==========================================
    // pin synchronisers
    // ==========================================
    logic [27:0] sync_a;
    logic [27:0] sync_b;
    logic [27:0] next_sync_a;
    always_comb begin
        next_sync_a = {addr[13:6], chip_enable_n, output_enable_n, write_enable_n, addr[5:0], data_in, addr[16:14]};
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync_a <= `RTCAW_SYNC_IDLE; // idle strobes, so no false access follows reset
            sync_b <= `RTCAW_SYNC_IDLE;
        end else begin
            sync_a <= next_sync_a;
            sync_b <= sync_a;
        end
    end
    // upper address bits only matter as a nonzero test; all bits above 5 must be zero
    logic [16:0] addr_s;
    logic ce_n_s;
    logic oe_n_s;
    logic we_n_s;
    logic [7:0] din_s;
    assign ce_n_s = sync_b[19];
    assign oe_n_s = sync_b[18];
    assign we_n_s = sync_b[17];
    assign din_s = sync_b[10:3];
    assign addr_s = {sync_b[2:0], sync_b[27:20], sync_b[16:11]};
    // ==========================================
    // access detection
    // ==========================================
    logic on_chip;
    logic sel;
    logic sel_d;
    logic rd_level;
    logic wr_q;
    logic wr_end;
    logic acc_start;
    logic [5:0] off;
    assign on_chip = (addr_s <= `RTCAW_REG_SPACE_TOP);
    assign off = addr_s[5:0];
    assign sel = !ce_n_s && on_chip && (!oe_n_s || !we_n_s);
    assign rd_level = !ce_n_s && on_chip && !oe_n_s && we_n_s;
    assign acc_start = sel && !sel_d;
    // write data latched at the end of the strobe, where setup is guaranteed
    assign wr_end = wr_q && !( !ce_n_s && !we_n_s);
    logic [5:0] wr_off;
    logic [5:0] next_wr_off;
    logic next_wr_q;
    always_comb begin
        next_wr_q = !ce_n_s && !we_n_s && on_chip;
        next_wr_off = next_wr_q ? off : wr_off;
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sel_d <= 1'b0;
            wr_q <= 1'b0;
            wr_off <= 6'h00;
        end else begin
            sel_d <= sel;
            wr_q <= next_wr_q;
            wr_off <= next_wr_off;
        end
    end
    logic alarm_access;
    logic wdog_access;
    always_comb begin
        alarm_access = acc_start && (off == `RTCAW_OFF_MIN_ALARM || off == `RTCAW_OFF_HOUR_ALARM
                                     || off == `RTCAW_OFF_DAY_ALARM);
        wdog_access = (acc_start && (off == `RTCAW_OFF_WDOG_LOW || off == `RTCAW_OFF_WDOG_HIGH))
                      || (wr_end && (wr_off == `RTCAW_OFF_WDOG_LOW || wr_off == `RTCAW_OFF_WDOG_HIGH));
    end
    // ==========================================
    // registers
    // ==========================================
    logic [7:0] min_alarm;
    logic [7:0] hour_alarm;
    logic [7:0] day_alarm;
    logic [7:0] cmd;
    logic [7:0] wdog_low;
    logic [7:0] wdog_high;
    logic [7:0] next_min_alarm;
    logic [7:0] next_hour_alarm;
    logic [7:0] next_day_alarm;
    logic [7:0] next_cmd;
    logic [7:0] next_wdog_low;
    logic [7:0] next_wdog_high;
    always_comb begin
        next_min_alarm = min_alarm;
        next_hour_alarm = hour_alarm;
        next_day_alarm = day_alarm;
        next_cmd = cmd;
        next_wdog_low = wdog_low;
        next_wdog_high = wdog_high;
        if (wr_end) begin
            unique case (wr_off)
                `RTCAW_OFF_MIN_ALARM: next_min_alarm = din_s;
                `RTCAW_OFF_HOUR_ALARM: next_hour_alarm = din_s;
                `RTCAW_OFF_DAY_ALARM: next_day_alarm = din_s & `RTCAW_DAY_ALARM_KEEP;
                `RTCAW_OFF_COMMAND: next_cmd = din_s & `RTCAW_CMD_RW_MASK;
                `RTCAW_OFF_WDOG_LOW: next_wdog_low = din_s;
                `RTCAW_OFF_WDOG_HIGH: next_wdog_high = din_s;
                default: next_cmd = cmd;
            endcase
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            min_alarm <= `RTCAW_RESET_BYTE;
            hour_alarm <= `RTCAW_RESET_BYTE;
            day_alarm <= `RTCAW_RESET_BYTE;
            cmd <= `RTCAW_CMD_RESET;
            wdog_low <= `RTCAW_RESET_BYTE;
            wdog_high <= `RTCAW_RESET_BYTE;
        end else begin
            min_alarm <= next_min_alarm;
            hour_alarm <= next_hour_alarm;
            day_alarm <= next_day_alarm;
            cmd <= next_cmd;
            wdog_low <= next_wdog_low;
            wdog_high <= next_wdog_high;
        end
    end
    rtcaw_pkg::rtcaw_cmd_t c;
    assign c = '{cmd[`RTCAW_CMD_XFER_EN], cmd[`RTCAW_CMD_SWAP], cmd[`RTCAW_CMD_POL],
                 cmd[`RTCAW_CMD_PULSE], cmd[`RTCAW_CMD_WDOG_MASK], cmd[`RTCAW_CMD_ALARM_MASK]};
    assign transfer_enable = c.transfer_enable;
    // ==========================================
    // 0.01 s time base
    // ==========================================
    logic [31:0] div_cnt;
    logic [31:0] next_div_cnt;
    logic next_tick;
    always_comb begin
        next_tick = (div_cnt == 32'(TICK_DIV - 1));
        next_div_cnt = next_tick ? 32'h0000_0000 : div_cnt + 32'h0000_0001;
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            div_cnt <= 32'h0000_0000;
            tick <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            tick <= next_tick;
        end
    end
    // ==========================================
    // time-of-day alarm compare
    // ==========================================
    logic m_mask;
    logic h_mask;
    logic d_mask;
    logic min_eq;
    logic hour_eq;
    logic day_eq;
    logic alarm_hit;
    assign m_mask = min_alarm[`RTCAW_MASK_BIT];
    assign h_mask = hour_alarm[`RTCAW_MASK_BIT];
    assign d_mask = day_alarm[`RTCAW_MASK_BIT];
    assign min_eq = (time_now.min[6:0] == min_alarm[6:0]);
    assign hour_eq = (time_now.hour[6:0] == hour_alarm[6:0]);
    assign day_eq = (time_now.day[2:0] == day_alarm[2:0]);
    always_comb begin
        alarm_hit = 1'b0;
        // checked in the last hundredth so the match lands on the minute boundary
        if (tick && time_now.hund == `RTCAW_HUND_LAST) begin
            if (m_mask && h_mask && d_mask) begin
                alarm_hit = (time_now.sec == `RTCAW_SEC_LAST);
            end else if (h_mask && d_mask) begin
                alarm_hit = min_eq && (time_now.sec == `RTCAW_SEC_LAST);
            end else if (d_mask) begin
                alarm_hit = min_eq && hour_eq && (time_now.sec == `RTCAW_SEC_LAST);
            end else begin
                alarm_hit = min_eq && hour_eq && day_eq && (time_now.sec == `RTCAW_SEC_LAST);
            end
        end
    end
    // ==========================================
    // watchdog countdown in BCD hundredths
    // ==========================================
    logic [15:0] wd_cnt;
    logic [15:0] next_wd_cnt;
    logic wd_hit;
    logic wd_enabled;
    assign wd_enabled = ({wdog_high, wdog_low} != 16'h0000);
    function automatic logic [15:0] rtcaw_bcd_dec(input logic [15:0] v);
        logic [15:0] r;
        r = v;
        if (v[3:0] != 4'h0) r[3:0] = v[3:0] - 4'h1;
        else if (v[7:4] != 4'h0) r[7:0] = {v[7:4] - 4'h1, 4'h9};
        else if (v[11:8] != 4'h0) r[11:0] = {v[11:8] - 4'h1, 8'h99};
        else r = {v[15:12] - 4'h1, 12'h999};
        return r;
    endfunction
    always_comb begin
        wd_hit = 1'b0;
        next_wd_cnt = wd_cnt;
        if (wdog_access) begin
            next_wd_cnt = {next_wdog_high, next_wdog_low};
        end else if (tick && wd_enabled) begin
            if (wd_cnt == 16'h0001 || wd_cnt == 16'h0000) begin
                wd_hit = 1'b1;
                next_wd_cnt = {wdog_high, wdog_low};
            end else begin
                next_wd_cnt = rtcaw_bcd_dec(wd_cnt);
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wd_cnt <= 16'h0000;
        end else begin
            wd_cnt <= next_wd_cnt;
        end
    end
    // ==========================================
    // flags and pulse timers
    // ==========================================
    logic tod_flag;
    logic wd_flag;
    logic next_tod_flag;
    logic next_wd_flag;
    logic [31:0] tod_pt;
    logic [31:0] wd_pt;
    logic [31:0] next_tod_pt;
    logic [31:0] next_wd_pt;
    always_comb begin
        // a new alarm event wins over a clearing access in the same cycle; a watchdog access reloads and suppresses the watchdog event
        next_tod_flag = alarm_hit || (tod_flag && !alarm_access);
        next_wd_flag = wd_hit || (wd_flag && !wdog_access);
        next_tod_pt = alarm_hit ? 32'(PULSE_CYC) : (tod_pt != 32'h0000_0000 ? tod_pt - 32'h0000_0001 : tod_pt);
        next_wd_pt = wd_hit ? 32'(PULSE_CYC) : (wd_pt != 32'h0000_0000 ? wd_pt - 32'h0000_0001 : wd_pt);
        if (c.irq_pulse_select) begin
            if (!alarm_hit && tod_pt <= 32'h0000_0001) next_tod_flag = 1'b0;
            if (!wd_hit && wd_pt <= 32'h0000_0001) next_wd_flag = 1'b0;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tod_flag <= 1'b0;
            wd_flag <= 1'b0;
            tod_pt <= 32'h0000_0000;
            wd_pt <= 32'h0000_0000;
        end else begin
            tod_flag <= next_tod_flag;
            wd_flag <= next_wd_flag;
            tod_pt <= next_tod_pt;
            wd_pt <= next_wd_pt;
        end
    end
    // ==========================================
    // interrupt routing and drive
    // ==========================================
    logic tod_act;
    logic wd_act;
    logic first_act;
    logic second_act;
    logic next_first_oe;
    logic next_second_oe;
    logic next_second_out;
    always_comb begin
        tod_act = tod_flag && !c.alarm_irq_mask;
        wd_act = wd_flag && !c.watchdog_irq_mask;
        first_act = c.irq_route_swap ? tod_act : wd_act;
        second_act = c.irq_route_swap ? wd_act : tod_act;
        next_first_oe = first_act;
        // active high sources, active low sinks; idle is released
        next_second_oe = second_act;
        next_second_out = c.second_irq_drive_polarity;
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_pin_first_oe <= 1'b0;
            irq_pin_second_oe <= 1'b0;
            irq_pin_second_out <= 1'b0;
        end else begin
            irq_pin_first_oe <= next_first_oe;
            irq_pin_second_oe <= next_second_oe;
            irq_pin_second_out <= next_second_out;
        end
    end
    assign irq_pin_first_out = 1'b0;
    // ==========================================
    // read data
    // ==========================================
    logic [7:0] next_data_out;
    always_comb begin
        unique case (off)
            `RTCAW_OFF_MIN_ALARM: next_data_out = min_alarm;
            `RTCAW_OFF_HOUR_ALARM: next_data_out = hour_alarm;
            `RTCAW_OFF_DAY_ALARM: next_data_out = day_alarm;
            `RTCAW_OFF_COMMAND: next_data_out = {cmd[7:2], wd_flag, tod_flag};
            `RTCAW_OFF_WDOG_LOW: next_data_out = wdog_low;
            `RTCAW_OFF_WDOG_HIGH: next_data_out = wdog_high;
            default: next_data_out = 8'h00;
        endcase
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            data_out <= 8'h00;
            data_oe <= 1'b0;
        end else begin
            data_out <= next_data_out;
            data_oe <= rd_level;
        end
    end
endmodule // rtcaw_top
`default_nettype wire

// ---- verif/rtcaw_chk_assertions.sv ----
// Purpose: port checks of the alarm/watchdog block
// Assumes: host holds strobes until data_oe and keeps addr after release
// Notes: a bus-access counter stands in for the hidden mode bits
`timescale 1ns/1ns
`default_nettype none
module rtcaw_chk #(
    parameter int PULSE_CYC = 20,
    parameter int TICK_DIV = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [16:0] addr,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire logic chip_enable_n,
    input wire logic output_enable_n,
    input wire logic write_enable_n,
    input wire logic tick,
    input wire logic transfer_enable,
    input wire logic irq_pin_first_out,
    input wire logic irq_pin_first_oe,
    input wire logic irq_pin_second_oe
);
    // ========
    // helpers
    int quiet;
    int gap;
    int hi1;
    int hi2;
    logic seen;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            quiet <= 100;
            gap <= 0;
            hi1 <= 0;
            hi2 <= 0;
            seen <= 1'b0;
        end else begin
            quiet <= chip_enable_n ? quiet + 1 : 0;
            gap <= tick ? 0 : gap + 1;
            hi1 <= irq_pin_first_oe ? hi1 + 1 : 0;
            hi2 <= irq_pin_second_oe ? hi2 + 1 : 0;
            seen <= seen | tick;
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // ========
    // sequences
    sequence rd_start;
        $fell(output_enable_n) && !chip_enable_n && write_enable_n && addr <= 17'h0_003f;
    endsequence
    sequence irq_up;
        $rose(irq_pin_first_oe) || $rose(irq_pin_second_oe);
    endsequence
    // ========
    // properties
    read_answer_a: assert property (rd_start |-> ##[1:6] data_oe)
        else $error("read without data enable");
    offchip_quiet_a: assert property ((addr > 17'h0_003f) [*5] |-> !data_oe)
        else $error("data enable off chip");
    day_zero_a: assert property (data_oe && addr[5:0] == 6'h07 |-> data_out[6:3] == 4'h0)
        else $error("day alarm bits not zero");
    unmapped_zero_a: assert property (
        data_oe && !(addr[5:0] inside {6'h03, 6'h05, 6'h07, 6'h0b, 6'h0c, 6'h0d}) |-> data_out == 8'h00)
        else $error("unmapped offset read nonzero");
    first_sink_a: assert property (irq_pin_first_oe |-> !irq_pin_first_out)
        else $error("first pin not sinking");
    // level mode ends only by access, pulse mode after the full width
    pulse_first_a: assert property ($fell(irq_pin_first_oe) |-> hi1 >= PULSE_CYC || quiet < 8)
        else $error("first pin released early");
    pulse_second_a: assert property ($fell(irq_pin_second_oe) |-> hi2 >= PULSE_CYC || quiet < 8)
        else $error("second pin released early");
    irq_cause_a: assert property (irq_up |-> gap < 3 || quiet < 8)
        else $error("interrupt without tick or access");
    tick_period_a: assert property (tick && seen |-> gap == TICK_DIV - 1)
        else $error("tick spacing wrong");
    reset_state_a: assert property (
        $fell(rst) |-> transfer_enable && !irq_pin_first_oe && !irq_pin_second_oe && !data_oe)
        else $error("wrong state after reset");
    xfer_write_a: assert property ($changed(transfer_enable) |-> quiet < 8)
        else $error("transfer enable moved without write");
endmodule // rtcaw_chk
`default_nettype wire

// ---- verif/rtcaw_host_model.sv ----
// Purpose: host processor on the bytewide bus
// Assumes: strobes low at least 4 cycles, high at least 4 between
// Notes: released data lines show the inverse of the last value
`timescale 1ns/1ns
`default_nettype none
module rtcaw_host_model (
    input wire logic sys_clk,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    output logic [16:0] addr,
    output logic [7:0] data_in,
    output logic chip_enable_n,
    output logic output_enable_n,
    output logic write_enable_n
);
    initial begin
        addr = 17'h0_0000;
        data_in = 8'h00;
        chip_enable_n = 1'b1;
        output_enable_n = 1'b1;
        write_enable_n = 1'b1;
    end
    // ========
    // write: data held past the late latch of the synced strobe
    task automatic wr(input logic [16:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        data_in <= d;
        chip_enable_n <= 1'b0;
        write_enable_n <= 1'b0;
        repeat (5) @(posedge sys_clk);
        chip_enable_n <= 1'b1;
        write_enable_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        data_in <= ~d;
        repeat (2) @(posedge sys_clk);
    endtask
    // ========
    // read: strobe held until data_oe is sampled, bounded
    task automatic rd(input logic [16:0] a, output logic [7:0] d, output logic ok);
        int n;
        n = 0;
        @(posedge sys_clk);
        addr <= a;
        chip_enable_n <= 1'b0;
        output_enable_n <= 1'b0;
        do begin
            @(posedge sys_clk);
            n++;
        end while ((n < 4 || data_oe !== 1'b1) && n < 12);
        ok = (data_oe === 1'b1);
        d = data_out;
        chip_enable_n <= 1'b1;
        output_enable_n <= 1'b1;
        repeat (5) @(posedge sys_clk);
    endtask
endmodule // rtcaw_host_model
`default_nettype wire

// ---- verif/test_rtc_alarm_watchdog_irq.sv ----
// Purpose: self-checking bench of the alarm/watchdog block
// Assumes: tick every 4 cycles, pulses of 20 cycles
// Notes: pins come from the host model, time inputs from the bench
`timescale 1ns/1ns
`default_nettype none
module test_rtc_alarm_watchdog_irq;
    typedef struct packed {logic [5:0] o; logic [7:0] d; logic [7:0] e;} rtcaw_row_t;
    typedef struct packed {logic [7:0] am; logic [7:0] ah; logic [7:0] ad; logic [23:0] t; logic x;} rtcaw_alm_t;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    rtcaw_pkg::rtcaw_time_t time_now = '0;
    logic [16:0] addr;
    logic [7:0] data_in;
    logic [7:0] data_out;
    logic data_oe, chip_enable_n, output_enable_n, write_enable_n, tick, transfer_enable;
    logic irq_pin_first_out, irq_pin_first_oe, irq_pin_second_out, irq_pin_second_oe;
    logic [7:0] got;
    logic ok;
    logic prev;
    int rises;
    int n_errors = 0;
    int samples_checked = 0;
    logic [5:0] offs [6] = '{6'h03, 6'h05, 6'h07, 6'h0b, 6'h0c, 6'h0d};
    logic [7:0] rstv [6] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00};
    rtcaw_row_t rows [8] = '{'{6'h03, 8'hd9, 8'hd9}, '{6'h05, 8'h72, 8'h72}, '{6'h07, 8'hff, 8'h87},
        '{6'h0c, 8'h45, 8'h45}, '{6'h0d, 8'h99, 8'h99}, '{6'h0b, 8'h83, 8'h80}, '{6'h02, 8'h5a, 8'h00},
        '{6'h0e, 8'h5a, 8'h00}};
    rtcaw_alm_t alm [7] = '{'{8'h15, 8'h08, 8'h03, 24'h15_0803, 1'b1}, '{8'h15, 8'h08, 8'h03, 24'h15_0804, 1'b0},
        '{8'h15, 8'h08, 8'h83, 24'h15_0805, 1'b1}, '{8'h15, 8'h08, 8'h83, 24'h15_0905, 1'b0},
        '{8'h15, 8'h88, 8'h83, 24'h15_1106, 1'b1}, '{8'h15, 8'h88, 8'h83, 24'h16_1106, 1'b0},
        '{8'h95, 8'h88, 8'h83, 24'h27_1106, 1'b1}};
    always #10 sys_clk = ~sys_clk;
    rtcaw_top #(.TICK_DIV(4), .PULSE_CYC(20)) DUT (.sys_clk(sys_clk), .rst(rst), .addr(addr), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .chip_enable_n(chip_enable_n), .output_enable_n(output_enable_n),
        .write_enable_n(write_enable_n), .time_now(time_now), .tick(tick), .transfer_enable(transfer_enable),
        .irq_pin_first_out(irq_pin_first_out), .irq_pin_first_oe(irq_pin_first_oe),
        .irq_pin_second_out(irq_pin_second_out), .irq_pin_second_oe(irq_pin_second_oe));
    rtcaw_host_model host (.sys_clk(sys_clk), .data_out(data_out), .data_oe(data_oe), .addr(addr),
        .data_in(data_in), .chip_enable_n(chip_enable_n), .output_enable_n(output_enable_n),
        .write_enable_n(write_enable_n));
    // ========
    // helpers
    task automatic chk(input logic c, input string m);
        samples_checked++;
        if (c !== 1'b1) begin
            n_errors++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic w(input logic [5:0] o, input logic [7:0] d);
        host.wr({11'h000, o}, d);
    endtask
    task automatic r(input logic [5:0] o);
        host.rd({11'h000, o}, got, ok);
    endtask
    task automatic st(input logic [7:0] h, input logic [23:0] mhd);
        @(posedge sys_clk);
        time_now <= {h, 8'h59, mhd};
    endtask
    task automatic await_first(input logic v);
        int n;
        n = 0;
        while (irq_pin_first_oe !== v && n < 80) begin
            @(posedge sys_clk);
            n++;
        end
        chk(irq_pin_first_oe === v, "pin wait timed out");
    endtask
    task automatic count_rises(input int len);
        rises = 0;
        prev = irq_pin_first_oe;
        repeat (len) begin
            @(posedge sys_clk);
            if (irq_pin_first_oe === 1'b1 && prev !== 1'b1)
                rises++;
            prev = irq_pin_first_oe;
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ========
    // main sequence
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        foreach (offs[i]) begin
            r(offs[i]);
            chk(got === rstv[i] && ok === 1'b1, "reset value");
        end
        $display("reset test done");
        foreach (rows[i]) begin
            w(rows[i].o, rows[i].d);
            r(rows[i].o);
            chk(got === rows[i].e && ok === 1'b1, "register readback");
        end
        $display("register test done");
        host.rd(17'h0_0047, got, ok);
        chk(ok === 1'b0, "off-chip read answered");
        host.wr(17'h0_0043, 8'h11);
        r(6'h03);
        chk(got === 8'hd9, "off-chip write landed");
        w(6'h0b, 8'h00);
        chk(transfer_enable === 1'b0, "freeze not taken");
        w(6'h0b, 8'h80);
        chk(transfer_enable === 1'b1, "freeze not released");
        $display("bus test done");
        foreach (alm[i]) begin
            w(6'h03, alm[i].am);
            w(6'h05, alm[i].ah);
            w(6'h07, alm[i].ad);
            st(8'h99, alm[i].t);
            repeat (16) @(posedge sys_clk);
            st(8'h00, alm[i].t);
            chk(irq_pin_second_oe === alm[i].x && irq_pin_second_out === 1'b0, "alarm pin");
            r(6'h0b);
            chk(got[0] === alm[i].x, "alarm flag");
            r(6'h03);
            chk(irq_pin_second_oe === 1'b0, "alarm not cleared");
        end
        $display("alarm test done");
        // alarm registers still hold the every-minute setting
        w(6'h0b, 8'he0);
        st(8'h99, 24'h00_0000);
        repeat (16) @(posedge sys_clk);
        st(8'h00, 24'h00_0000);
        chk(irq_pin_first_oe === 1'b1 && irq_pin_second_oe === 1'b0, "routing");
        chk(irq_pin_second_out === 1'b1, "second pin polarity");
        w(6'h0b, 8'he4);
        chk(irq_pin_first_oe === 1'b0, "alarm mask");
        r(6'h0b);
        chk(got === 8'he5, "flag under mask");
        r(6'h03);
        $display("routing test done");
        w(6'h0b, 8'h90);
        w(6'h0c, 8'h10);
        w(6'h0d, 8'h00);
        count_rises(130);
        chk(rises == 3, "watchdog repeat count");
        await_first(1'b1);
        r(6'h0b);
        chk(got[1] === 1'b1, "flag during pulse");
        await_first(1'b0);
        r(6'h0b);
        chk(got[1] === 1'b0, "flag after pulse");
        w(6'h0c, 8'h00);
        count_rises(100);
        chk(rises == 0, "zero period fired");
        $display("watchdog test done");
        w(6'h0b, 8'h48);
        w(6'h0c, 8'h03);
        repeat (40) @(posedge sys_clk);
        chk(irq_pin_second_oe === 1'b0 && irq_pin_first_oe === 1'b0, "watchdog mask");
        r(6'h0b);
        chk(got === 8'h4a, "watchdog flag");
        w(6'h0b, 8'h40);
        chk(irq_pin_second_oe === 1'b1, "unmasked watchdog pin");
        r(6'h0c);
        chk(got === 8'h03, "loaded period read");
        w(6'h0c, 8'h00);
        $display("mask test done");
        print_verdict();
    end
    // hang guard, far beyond the expected run of under 2000 cycles
    initial begin
        #400000;
        n_errors++;
        $display("MISMATCH %0t run too long", $time);
        print_verdict();
    end
endmodule // test_rtc_alarm_watchdog_irq
bind rtcaw_top rtcaw_chk #(.PULSE_CYC(PULSE_CYC), .TICK_DIV(TICK_DIV)) u_chk (.sys_clk(sys_clk), .rst(rst),
    .addr(addr), .data_out(data_out), .data_oe(data_oe), .chip_enable_n(chip_enable_n),
    .output_enable_n(output_enable_n), .write_enable_n(write_enable_n), .tick(tick),
    .transfer_enable(transfer_enable), .irq_pin_first_out(irq_pin_first_out),
    .irq_pin_first_oe(irq_pin_first_oe), .irq_pin_second_oe(irq_pin_second_oe));
`default_nettype wire
